// File: rtl/trap_capture_pkg.sv
package trap_capture_pkg;

	// Port addresses of the capture registers and the trap control word.
	localparam logic [15:0] ADDR_CAPTURE_LOW = 16'h8C72;
	localparam logic [15:0] ADDR_CAPTURE_HIGH = 16'h9472;
	localparam logic [15:0] ADDR_TRAP_CONTROL = 16'h7C72;

	// Position of the trap-status bit inside the trap control word.
	localparam int TRAP_STATUS_POS = 7;

	// Reset values of the capture registers and of the read data register.
	localparam logic [15:0] CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] READ_IDLE = 16'h0000;

	// Number of chip-select ranges that own an inactivity timer.
	localparam int RANGE_COUNT = 5;
	localparam int LIMIT_W = 5;

	// Timeout base unit and the system clock rate.
	localparam int TIMEOUT_UNIT_S = 4;
	localparam int CLK_SYS_HZ = 200000000;
	localparam int UNIT_CYCLES = TIMEOUT_UNIT_S * CLK_SYS_HZ;
	localparam int UNIT_CNT_W = 30;

	// Transfer size and ordering codes shared by I/O and memory status.
	typedef enum logic [2:0] {
		XFER_NONE = 3'h0,
		XFER_16 = 3'h1,
		XFER_32 = 3'h2,
		XFER_32_SUB2 = 3'h3,
		XFER_32_SUB1 = 3'h4,
		XFER_8 = 3'h5,
		XFER_16_ODD = 3'h6,
		XFER_32_SUB3 = 3'h7
	} xfer_code_t;

	// Capture sequencer states, Gray coded along the usual path.
	typedef enum logic [1:0] {
		CAP_ARMED = 2'h0,
		CAP_TRAPPED = 2'h1,
		CAP_MEM_HELD = 2'h3
	} cap_state_t;

endpackage

// File: rtl/inactivity_timer.sv
module inactivity_timer
	import trap_capture_pkg::*;
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Time base and range activity.
	input wire logic unitTick,
	input wire logic rangeAccess,
	// Software settings for this range.
	input wire logic timeoutEnable,
	input wire logic [LIMIT_W-1:0] timeoutLimit,
	// Sticky timeout status.
	output logic timedOut
);

	logic [LIMIT_W-1:0] count_q, count_d;
	logic timedOut_q, timedOut_d;
	logic expire;

	// A timeout fires when the idle count reaches a nonzero limit.
	assign expire = timeoutEnable && unitTick && !rangeAccess &&
		(timeoutLimit != '0) && (count_q == timeoutLimit - 5'h01);

	// Idle counter restarts on access; status clears only when disabled.
	always_comb begin
		count_d = count_q;
		timedOut_d = timedOut_q;
		if (!timeoutEnable || rangeAccess) begin
			count_d = '0;
		end else if (unitTick && !timedOut_q && !expire) begin
			count_d = count_q + 5'h01;
		end
		if (!timeoutEnable) begin
			timedOut_d = 1'b0;
		end else if (expire) begin
			timedOut_d = 1'b1;
		end
	end

	// State registers.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			count_q <= '0;
			timedOut_q <= 1'b0;
		end else begin
			count_q <= count_d;
			timedOut_q <= timedOut_d;
		end
	end

	assign timedOut = timedOut_q;

endmodule

// File: rtl/io_trap_capture.sv
module io_trap_capture
	import trap_capture_pkg::*;
#(
	parameter int UNIT_TICK_CYCLES = UNIT_CYCLES
)
(
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic reset,
	// Processor I/O cycle monitor.
	input wire logic ioCycle,
	input wire logic ioWrite,
	input wire logic [RANGE_COUNT-1:0] rangeHit,
	input wire logic [31:0] ioWriteData,
	input wire logic [2:0] ioTransferCodeIn,
	input wire logic ioAddrBit0,
	// Processor memory write monitor.
	input wire logic memWrite,
	input wire logic [23:0] memAddr,
	input wire logic [2:0] memTransferCodeIn,
	input wire logic smiActive,
	input wire logic stringInActive,
	// Settings held in neighbouring registers.
	input wire logic [RANGE_COUNT-1:0] trapEnable,
	input wire logic [RANGE_COUNT-1:0] timeoutEnable,
	input wire logic [RANGE_COUNT*LIMIT_W-1:0] timeoutLimit,
	// Handler port access.
	input wire logic portWrite,
	input wire logic portRead,
	input wire logic [15:0] portAddr,
	input wire logic [15:0] portWriteData,
	output logic [15:0] portReadData,
	output logic portReadValid,
	// Status and interrupt request.
	output logic trapStatus,
	output logic ioWriteStatus,
	output logic [2:0] ioTransferCode,
	output logic [2:0] memTransferCode,
	output logic [RANGE_COUNT-1:0] timeoutStatus,
	output logic smiRequest
);

	cap_state_t state_q, state_d;
	logic [15:0] capLow_q, capLow_d;
	logic [15:0] capHigh_q, capHigh_d;
	logic ioWs_q, ioWs_d;
	logic [2:0] ioCode_q, ioCode_d;
	logic [2:0] memCode_q, memCode_d;
	logic [15:0] rdData_q, rdData_d;
	logic rdValid_q, rdValid_d;
	logic [UNIT_CNT_W-1:0] pre_q, pre_d;
	logic unitTick;
	logic trapClear;
	logic ioTrapHit;
	logic memCapture;
	logic [31:0] placed;
	logic [RANGE_COUNT-1:0] rangeAccess;

	// Orders the trapped I/O write bytes as the transfer code demands.
	function automatic logic [31:0] placeIo(input logic [2:0] code,
		input logic bit0, input logic [31:0] d);
		logic [7:0] b0, b1, b2, b3;
		b0 = d[7:0];
		b1 = d[15:8];
		b2 = d[23:16];
		b3 = d[31:24];
		case (code)
			XFER_16: placeIo = {16'h0000, b1, b0};
			XFER_32: placeIo = {b3, b2, b1, b0};
			XFER_32_SUB2: placeIo = {b1, b0, b3, b2};
			XFER_32_SUB1: placeIo = {b0, b3, b2, b1};
			XFER_8: placeIo = bit0 ? {16'h0000, b0, 8'h00}
				: {16'h0000, 8'h00, b0};
			XFER_16_ODD: placeIo = {16'h0000, b0, b1};
			XFER_32_SUB3: placeIo = {b2, b1, b0, b3};
			default: placeIo = 32'h0000_0000;
		endcase
	endfunction

	// Event decode: trap on an enabled range, clear on a zero status write.
	assign trapClear = portWrite && (portAddr == ADDR_TRAP_CONTROL) &&
		!portWriteData[TRAP_STATUS_POS];
	assign ioTrapHit = ioCycle && ((rangeHit & trapEnable) != '0);
	assign memCapture = (state_q == CAP_TRAPPED) && !ioWs_q && memWrite &&
		smiActive && stringInActive && !trapClear;
	assign placed = placeIo(ioTransferCodeIn, ioAddrBit0, ioWriteData);

	// Capture sequencer; a trap in the clearing cycle is kept.
	always_comb begin
		state_d = state_q;
		capLow_d = capLow_q;
		capHigh_d = capHigh_q;
		ioWs_d = ioWs_q;
		ioCode_d = ioCode_q;
		memCode_d = memCode_q;
		case (state_q)
			CAP_ARMED: begin
				if (ioTrapHit) begin
					state_d = CAP_TRAPPED;
					ioWs_d = ioWrite;
					ioCode_d = ioTransferCodeIn;
					if (ioWrite) begin
						capLow_d = placed[15:0];
						capHigh_d = placed[31:16];
					end
				end
			end
			CAP_TRAPPED: begin
				if (trapClear) begin
					state_d = CAP_ARMED;
					capLow_d = CAPTURE_RESET;
					capHigh_d = CAPTURE_RESET;
					ioWs_d = 1'b0;
					ioCode_d = XFER_NONE;
					memCode_d = XFER_NONE;
				end else if (memCapture) begin
					state_d = CAP_MEM_HELD;
					capLow_d = memAddr[15:0];
					capHigh_d = {8'h00, memAddr[23:16]};
					memCode_d = memTransferCodeIn;
				end
			end
			CAP_MEM_HELD: begin
				if (trapClear) begin
					state_d = CAP_ARMED;
					capLow_d = CAPTURE_RESET;
					capHigh_d = CAPTURE_RESET;
					ioWs_d = 1'b0;
					ioCode_d = XFER_NONE;
					memCode_d = XFER_NONE;
				end
			end
			default: state_d = CAP_ARMED;
		endcase
		if (trapClear && ioTrapHit) begin
			state_d = CAP_TRAPPED;
			ioWs_d = ioWrite;
			ioCode_d = ioTransferCodeIn;
			capLow_d = ioWrite ? placed[15:0] : CAPTURE_RESET;
			capHigh_d = ioWrite ? placed[31:16] : CAPTURE_RESET;
			memCode_d = XFER_NONE;
		end
	end

	// Capture registers.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state_q <= CAP_ARMED;
			capLow_q <= CAPTURE_RESET;
			capHigh_q <= CAPTURE_RESET;
			ioWs_q <= 1'b0;
			ioCode_q <= XFER_NONE;
			memCode_q <= XFER_NONE;
		end else begin
			state_q <= state_d;
			capLow_q <= capLow_d;
			capHigh_q <= capHigh_d;
			ioWs_q <= ioWs_d;
			ioCode_q <= ioCode_d;
			memCode_q <= memCode_d;
		end
	end

	// Read port; writes to the capture addresses are ignored.
	always_comb begin
		rdValid_d = portRead;
		rdData_d = READ_IDLE;
		if (portRead && portAddr == ADDR_CAPTURE_LOW) begin
			rdData_d = capLow_q;
		end else if (portRead && portAddr == ADDR_CAPTURE_HIGH) begin
			rdData_d = capHigh_q;
		end
	end

	// Read data register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdData_q <= READ_IDLE;
			rdValid_q <= 1'b0;
		end else begin
			rdData_q <= rdData_d;
			rdValid_q <= rdValid_d;
		end
	end

	// Prescaler that produces the timeout unit tick.
	always_comb begin
		if (pre_q == UNIT_CNT_W'(UNIT_TICK_CYCLES - 1)) begin
			pre_d = '0;
		end else begin
			pre_d = pre_q + 30'h0000_0001;
		end
	end

	// Prescaler register.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pre_q <= '0;
		end else begin
			pre_q <= pre_d;
		end
	end

	assign unitTick = (pre_q == UNIT_CNT_W'(UNIT_TICK_CYCLES - 1));

	// One inactivity timer for each chip-select range.
	generate
		for (genvar r = 0; r < RANGE_COUNT; r++) begin : g_timer
			assign rangeAccess[r] = ioCycle && rangeHit[r];
			inactivity_timer u_timer (
				.clk_sys(clk_sys),
				.reset(reset),
				.unitTick(unitTick),
				.rangeAccess(rangeAccess[r]),
				.timeoutEnable(timeoutEnable[r]),
				.timeoutLimit(timeoutLimit[r*LIMIT_W +: LIMIT_W]),
				.timedOut(timeoutStatus[r])
			);
		end
	endgenerate

	// Outputs.
	assign portReadData = rdData_q;
	assign portReadValid = rdValid_q;
	assign trapStatus = (state_q != CAP_ARMED);
	assign ioWriteStatus = ioWs_q;
	assign ioTransferCode = ioCode_q;
	assign memTransferCode = memCode_q;
	assign smiRequest = trapStatus || (timeoutStatus != '0);

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_clear_alone;
		trapClear && !ioTrapHit;
	endsequence

	sequence s_held;
		trapStatus && !trapClear && !memCapture;
	endsequence

	property p_clear_zero;
		s_clear_alone |=> capLow_q == 16'h0000 && capHigh_q == 16'h0000
			&& !trapStatus;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("no clear");

	property p_write_flag;
		!trapStatus && ioTrapHit |=> ioWriteStatus == $past(ioWrite);
	endproperty
	a_write_flag: assert property (p_write_flag) else $error("bad iows");

	property p_hold;
		s_held |=> $stable(capLow_q) && $stable(capHigh_q);
	endproperty
	a_hold: assert property (p_hold) else $error("capture moved");

	property p_mem_addr;
		memCapture |=> capLow_q == $past(memAddr[15:0]) &&
			capHigh_q == {8'h00, $past(memAddr[23:16])} &&
			memTransferCode == $past(memTransferCodeIn);
	endproperty
	a_mem_addr: assert property (p_mem_addr) else $error("bad addr");

	property p_mem_cause;
		memTransferCode != 3'h0 && $past(memTransferCode) == 3'h0 &&
			$past(!reset) |-> $past(smiActive && stringInActive);
	endproperty
	a_mem_cause: assert property (p_mem_cause) else $error("bad mem");

	property p_first_only;
		memTransferCode != 3'h0 && !trapClear |=> $stable(memTransferCode)
			&& $stable(capLow_q);
	endproperty
	a_first_only: assert property (p_first_only) else $error("overrun");

	property p_order32;
		!trapStatus && ioTrapHit && ioWrite && ioTransferCodeIn == 3'h4
			|=> capHigh_q == {$past(ioWriteData[7:0]),
			$past(ioWriteData[31:24])};
	endproperty
	a_order32: assert property (p_order32) else $error("bad order");

	property p_read_low;
		portRead && portAddr == ADDR_CAPTURE_LOW |=> portReadValid &&
			portReadData == $past(capLow_q);
	endproperty
	a_read_low: assert property (p_read_low) else $error("bad read");

	property p_timeout_smi;
		(timeoutStatus & ~$past(timeoutStatus)) != '0 |->
			$past(unitTick) && smiRequest &&
			(timeoutStatus & ~$past(timeoutStatus) & $past(rangeAccess))
			== '0;
	endproperty
	a_timeout_smi: assert property (p_timeout_smi) else $error("no smi");

endmodule

// File: verif/host_model.sv
module host_model
	import trap_capture_pkg::*;
(
	// Clock.
	input wire logic clk_sys,
	// Processor I/O cycle.
	output logic ioCycle,
	output logic ioWrite,
	output logic [RANGE_COUNT-1:0] rangeHit,
	output logic [31:0] ioWriteData,
	output logic [2:0] ioTransferCodeIn,
	output logic ioAddrBit0,
	// Processor memory write.
	output logic memWrite,
	output logic [23:0] memAddr,
	output logic [2:0] memTransferCodeIn,
	output logic smiActive,
	output logic stringInActive,
	// Handler port access.
	output logic portWrite,
	output logic portRead,
	output logic [15:0] portAddr,
	output logic [15:0] portWriteData,
	input wire logic [15:0] portReadData,
	input wire logic portReadValid
);
	timeunit 1ns;
	timeprecision 1ps;

	// Everything idles low until the first request.
	initial begin
		{ioCycle, ioWrite, rangeHit, ioWriteData, ioTransferCodeIn} = '0;
		{ioAddrBit0, memWrite, memAddr, memTransferCodeIn} = '0;
		{smiActive, stringInActive, portWrite, portRead} = '0;
		{portAddr, portWriteData} = '0;
	end

	// One processor I/O cycle; released data shows its inverse.
	task io_cycle(input logic wr, input logic [4:0] hit, input logic [31:0] d,
			input logic [2:0] c, input logic b0);
		@(negedge clk_sys);
		{ioCycle, ioWrite, rangeHit, ioWriteData} = {1'b1, wr, hit, d};
		{ioTransferCodeIn, ioAddrBit0} = {c, b0};
		@(negedge clk_sys);
		{ioCycle, rangeHit, ioWriteData} = {1'b0, 5'h00, ~d};
	endtask

	// Interrupt and string-input levels.
	task set_mode(input logic s, input logic t);
		@(negedge clk_sys);
		{smiActive, stringInActive} = {s, t};
	endtask

	// One memory write cycle.
	task mem_write(input logic [23:0] a, input logic [2:0] c);
		@(negedge clk_sys);
		{memWrite, memAddr, memTransferCodeIn} = {1'b1, a, c};
		@(negedge clk_sys);
		{memWrite, memAddr} = {1'b0, ~a};
	endtask

	// Handler port write strobe.
	task port_write(input logic [15:0] a, input logic [15:0] d);
		@(negedge clk_sys);
		{portWrite, portAddr, portWriteData} = {1'b1, a, d};
		@(negedge clk_sys);
		{portWrite, portWriteData} = {1'b0, ~d};
	endtask

	// Handler port read; the answer stands in the cycle after the strobe.
	task port_read(input logic [15:0] a, output logic [15:0] d,
			output logic v);
		@(negedge clk_sys);
		{portRead, portAddr} = {1'b1, a};
		@(negedge clk_sys);
		{d, v} = {portReadData, portReadValid};
		portRead = 1'b0;
	endtask
endmodule

// File: verif/testbench.sv
module testbench
	import trap_capture_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_sys, reset, ioCycle, ioWrite, ioAddrBit0, memWrite;
	logic smiActive, stringInActive, portWrite, portRead, portReadValid;
	logic trapStatus, ioWriteStatus, smiRequest;
	logic [4:0] rangeHit, trapEnable, timeoutEnable, timeoutStatus;
	logic [31:0] ioWriteData;
	logic [2:0] ioTransferCodeIn, memTransferCodeIn;
	logic [2:0] ioTransferCode, memTransferCode;
	logic [23:0] memAddr;
	logic [24:0] timeoutLimit;
	logic [15:0] portAddr, portWriteData, portReadData;
	int err_total, checked;

	io_trap_capture #(.UNIT_TICK_CYCLES(10)) i_io_trap_capture(.clk_sys,
		.reset, .ioCycle, .ioWrite, .rangeHit, .ioWriteData,
		.ioTransferCodeIn, .ioAddrBit0, .memWrite, .memAddr,
		.memTransferCodeIn, .smiActive, .stringInActive, .trapEnable,
		.timeoutEnable, .timeoutLimit, .portWrite, .portRead, .portAddr,
		.portWriteData, .portReadData, .portReadValid, .trapStatus,
		.ioWriteStatus, .ioTransferCode, .memTransferCode, .timeoutStatus,
		.smiRequest);
	host_model i_host_model(.clk_sys, .ioCycle, .ioWrite, .rangeHit,
		.ioWriteData, .ioTransferCodeIn, .ioAddrBit0, .memWrite, .memAddr,
		.memTransferCodeIn, .smiActive, .stringInActive, .portWrite,
		.portRead, .portAddr, .portWriteData, .portReadData, .portReadValid);

	// Clock generator.
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Compares one value and reports a mismatch at once.
	task check(input logic [15:0] got, input logic [15:0] exp, input string m);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// Reads a register and compares valid strobe and data.
	task rd_check(input logic [15:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic v;
		i_host_model.port_read(a, d, v);
		check({15'h0, v}, 16'h0001, "read valid");
		check(d, exp, "read data");
	endtask

	// Writes zero to the trap-status bit.
	task clear_trap;
		i_host_model.port_write(ADDR_TRAP_CONTROL, 16'h0000);
	endtask

	// Prints counts and the verdict, then stops.
	task give_verdict;
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Captures read back zero after reset.
	task test_reset;
		rd_check(ADDR_CAPTURE_LOW, 16'h0000);
		rd_check(ADDR_CAPTURE_HIGH, 16'h0000);
		check({15'h0, smiRequest}, 16'h0000, "idle interrupt");
		$display("test_reset done");
	endtask

	// Every I/O write code, with refused retrap and read-only writes.
	task test_io_write;
		logic [15:0] hi, lo;
		logic [2:0] c;
		for (int i = 1; i <= 8; i++) begin
			c = (i == 8) ? 3'h5 : 3'(i);
			case (i)
				1: {hi, lo} = 32'h0000_2211;
				2: {hi, lo} = 32'h4433_2211;
				3: {hi, lo} = 32'h2211_4433;
				4: {hi, lo} = 32'h1144_3322;
				5: {hi, lo} = 32'h0000_0011;
				6: {hi, lo} = 32'h0000_1122;
				7: {hi, lo} = 32'h3322_1144;
				default: {hi, lo} = 32'h0000_1100;
			endcase
			i_host_model.io_cycle(1'b1, 5'h01, 32'h44332211, c, i == 8);
			check({13'h0, trapStatus, ioWriteStatus, smiRequest}, 16'h0007,
				"trap flags");
			check({13'h0, ioTransferCode}, {13'h0, c}, "io code");
			i_host_model.io_cycle(1'b1, 5'h01, 32'hFFFFFFFF, 3'h2, 1'b0);
			i_host_model.port_write(ADDR_CAPTURE_LOW, 16'hFFFF);
			i_host_model.port_write(ADDR_TRAP_CONTROL, 16'h0080);
			rd_check(ADDR_CAPTURE_LOW, lo);
			rd_check(ADDR_CAPTURE_HIGH, hi);
			check({15'h0, trapStatus}, 16'h0001, "status kept");
			clear_trap();
			check({15'h0, trapStatus}, 16'h0000, "cleared");
			rd_check(ADDR_CAPTURE_LOW, 16'h0000);
		end
		// A trap in the clearing cycle is kept with its new capture.
		i_host_model.io_cycle(1'b0, 5'h01, 32'h0, 3'h1, 1'b0);
		fork
			clear_trap();
			i_host_model.io_cycle(1'b1, 5'h01, 32'h00005566, 3'h1, 1'b0);
		join
		check({14'h0, trapStatus, ioWriteStatus}, 16'h0003, "set wins");
		rd_check(ADDR_CAPTURE_LOW, 16'h5566);
		clear_trap();
		check({15'h0, trapStatus}, 16'h0000, "cleared again");
		$display("test_io_write done");
	endtask

	// Memory address capture after a read trap, every code.
	task test_mem;
		logic [23:0] a;
		i_host_model.io_cycle(1'b0, 5'h01, 32'h44332211, 3'h1, 1'b0);
		check({15'h0, ioWriteStatus}, 16'h0000, "read trap");
		i_host_model.set_mode(1'b0, 1'b1);
		i_host_model.mem_write(24'h123456, 3'h1);
		i_host_model.set_mode(1'b1, 1'b0);
		i_host_model.mem_write(24'h234567, 3'h2);
		check({13'h0, memTransferCode}, 16'h0000, "no capture");
		rd_check(ADDR_CAPTURE_LOW, 16'h0000);
		clear_trap();
		i_host_model.set_mode(1'b1, 1'b1);
		for (int c = 1; c <= 7; c++) begin
			a = 24'hC4B2A0 + 24'(c * 24'h010101);
			i_host_model.io_cycle(1'b0, 5'h01, 32'h0, 3'h1, 1'b0);
			i_host_model.mem_write(a, 3'(c));
			i_host_model.mem_write(~a, 3'h7);
			check({13'h0, memTransferCode}, 16'(c), "mem code");
			rd_check(ADDR_CAPTURE_LOW, a[15:0]);
			rd_check(ADDR_CAPTURE_HIGH, {8'h00, a[23:16]});
			clear_trap();
		end
		i_host_model.set_mode(1'b0, 1'b0);
		$display("test_mem done");
	endtask

	// Idle timeout, restart by access, then wake-up trap.
	task test_timer;
		int n;
		@(negedge clk_sys);
		{timeoutLimit, timeoutEnable, trapEnable} = {25'h2, 5'h01, 5'h00};
		repeat (12) begin
			repeat (5) @(negedge clk_sys);
			i_host_model.io_cycle(1'b0, 5'h01, 32'h0, 3'h1, 1'b0);
		end
		check({11'h0, timeoutStatus}, 16'h0000, "restarted");
		n = 0;
		while (timeoutStatus[0] !== 1'b1 && n < 40) begin
			@(negedge clk_sys);
			n++;
		end
		check({14'h0, timeoutStatus[0], smiRequest}, 16'h0003,
			"timeout");
		trapEnable = 5'h01;
		i_host_model.io_cycle(1'b1, 5'h01, 32'h0000ABCD, 3'h1, 1'b0);
		check({15'h0, trapStatus}, 16'h0001, "wake trap");
		rd_check(ADDR_CAPTURE_LOW, 16'hABCD);
		@(negedge clk_sys);
		timeoutEnable = 5'h00;
		clear_trap();
		check({10'h0, timeoutStatus, smiRequest}, 16'h0000, "off");
		$display("test_timer done");
	endtask

	// Watchdog against a hang.
	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		give_verdict();
	end

	// Main sequence.
	initial begin
		{err_total, checked} = '0;
		{reset, trapEnable, timeoutEnable, timeoutLimit} = {1'b1, 35'h0};
		repeat (3) @(negedge clk_sys);
		reset = 1'b0;
		trapEnable = 5'h01;
		test_reset();
		test_io_write();
		test_mem();
		test_timer();
		give_verdict();
	end
endmodule
